// ===== bip_pkg.sv
// Constants and register map of the board interrupt prioritizer.
// Overview of operation
// - Fully nested mode ranks level 0 highest and level 7 lowest.
// - Auto-rotating mode makes the level just serviced the lowest priority.
// - Specific mode ranks levels in sequence after a software-named lowest level.
// - Polled mode exposes the highest pending level in a readable status register.
// - Mode and priority settings may be rewritten any time without reset.
// - Interrupt raised only when best pending request outranks the level in service.
// - One byte write to the mask register masks any set of levels.
// - Each level gets its own vector, 4 bytes apart, block placeable in low 1K.
// - Twenty-six selectable request sources are routed to the prioritizer.
// - Parallel port raises input-full and output-empty requests.
// - Eight prioritized system bus request lines are accepted.
// - Timers, fail-safe timer, six expansion lines, conversion, power-fail, line clock.
// - Power-fail control combines power-fail request with the mains low warning.
// - Non-maskable line goes straight to the processor, vectored through 00008H.
// - Each level is programmable as edge-sensitive or level-sensitive.
package bip_pkg;
    localparam int NLVL = 8;
    localparam int NSRC = 26;
    // Register byte offsets.
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_BASE = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_TRIG = 8'h0c;
    localparam logic [7:0] A_ROUTE0 = 8'h10;
    localparam logic [7:0] A_ROUTE1 = 8'h14;
    localparam logic [7:0] A_EOI = 8'h18;
    localparam logic [7:0] A_POLL = 8'h1c;
    localparam logic [7:0] A_PEND = 8'h20;
    localparam logic [7:0] A_EVSTAT = 8'h24;
    localparam logic [7:0] A_EVEN = 8'h28;
    localparam logic [7:0] A_EVCLR = 8'h2c;
    // Priority modes held in the mode register bits 1:0.
    localparam logic [1:0] M_NEST = 2'h0;
    localparam logic [1:0] M_ROT = 2'h1;
    localparam logic [1:0] M_SPEC = 2'h2;
    localparam logic [1:0] M_POLL = 2'h3;
    localparam int MODE_LOW_POS = 4;
    // Source indices on the request source vector.
    localparam int SRC_PPI_IN = 0;
    localparam int SRC_PPI_OUT = 1;
    localparam int SRC_PIO_LINE = 2;
    localparam int SRC_TMR0 = 3;
    localparam int SRC_FAILSAFE = 6;
    localparam int SRC_SYSBUS0 = 7;
    localparam int SRC_EXP0 = 15;
    localparam int SRC_EOC = 21;
    localparam int SRC_PFAIL = 22;
    localparam int SRC_LINECLK = 23;
    localparam int SRC_AUX0 = 24;
    // Reset values.
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] LOW_RST = 3'h7;
    localparam logic [4:0] BASE_RST = 5'h08;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] TRIG_RST = 8'hff;
    localparam logic [31:0] ROUTE0_RST = 32'h0a090807;
    localparam logic [31:0] ROUTE1_RST = 32'h0e0d0c0b;
    // Event status bits.
    localparam int EVW = 3;
    localparam int EV_PFAIL = 0;
    localparam int EV_MLOW = 1;
    localparam int EV_SPUR = 2;
    localparam logic [2:0] SPUR_LVL = 3'h7;
    localparam logic [19:0] NMI_VEC_ADDR = 20'h00008;
endpackage

// ===== bip_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module bip_sync #(
    parameter int W = 27
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous pins and their synchronised copy.
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;
endmodule
`default_nettype wire

// ===== bip_prio.sv
// Rotating priority resolver for eight levels.
`timescale 1ns/10ps
`default_nettype none
module bip_prio (
    // Pending, in-service and lowest level.
    input wire logic [7:0] req_i,
    input wire logic [7:0] isr_i,
    input wire logic [2:0] low_i,
    // Best pending and top in-service level.
    output logic [2:0] best_o,
    output logic best_vld_o,
    output logic [2:0] top_o,
    output logic top_vld_o,
    output logic grant_o
);
    logic [2:0] lvl;
    logic [3:0] best_rank;
    logic [3:0] top_rank;

    // Scan from rank 7 down to rank 0 so the last hit wins; rank 0 is the level after low_i.
    always_comb begin
        lvl = '0;
        best_o = '0;
        top_o = '0;
        best_vld_o = 1'b0;
        top_vld_o = 1'b0;
        best_rank = 4'h8;
        top_rank = 4'h8;
        for (int k = 7; k >= 0; k--) begin
            lvl = 3'(low_i + 3'h1 + 3'(k));
            if (req_i[lvl]) begin
                best_o = lvl;
                best_vld_o = 1'b1;
                best_rank = 4'(k);
            end
            if (isr_i[lvl]) begin
                top_o = lvl;
                top_vld_o = 1'b1;
                top_rank = 4'(k);
            end
        end
        grant_o = best_vld_o && (best_rank < top_rank);
    end
endmodule
`default_nettype wire

// ===== bip_core.sv
// Board interrupt prioritizer with Wishbone register access.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module bip_core (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Request sources and power supply warning pins.
    input wire logic [25:0] src_i,
    input wire logic mains_low_warning_i,
    // Processor side.
    input wire logic inta_i,
    output logic int_o,
    output logic [7:0] vec_o,
    output logic vec_valid_o,
    output logic nmi_o,
    // Event interrupt.
    output logic evt_irq_o
);
    localparam int NL = bip_pkg::NLVL;

    // Picks one source of the source vector; indices past the last source read as zero.
    function automatic logic pick_src(input logic [25:0] s, input logic [4:0] idx);
        logic r;
        r = 1'b0;
        if (idx < 5'(bip_pkg::NSRC)) begin
            r = s[idx];
        end
        return r;
    endfunction

    // True when the write has byte lane k enabled on the register at address a.
    function automatic logic lane_wr(input logic w, input logic [7:0] adr,
                                     input logic [7:0] a, input logic [3:0] sel, input int k);
        return w && (adr == a) && sel[k];
    endfunction

    logic [26:0] pin_s;
    logic [7:0] raw;
    logic [7:0] req;
    logic [2:0] low;
    logic [2:0] best;
    logic [2:0] top;
    logic best_vld;
    logic top_vld;
    logic grant;
    logic bus_req;
    logic wr;
    logic rd;
    logic take;
    logic spur;
    logic pf_s;
    logic ml_s;

    logic [1:0] mode_q, mode_d;
    logic [2:0] low_q, low_d;
    logic [4:0] base_q, base_d;
    logic [7:0] mask_q, mask_d;
    logic [7:0] trig_q, trig_d;
    logic [4:0] route_q [NL];
    logic [4:0] route_d [NL];
    logic [2:0] armed_q, armed_d;
    logic [bip_pkg::EVW-1:0] en_q, en_d;
    logic [bip_pkg::EVW-1:0] stat_q, stat_d;
    logic [7:0] irr_q, irr_d;
    logic [7:0] isr_q, isr_d;
    logic [7:0] prev_q, prev_d;
    logic [2:0] rot_q, rot_d;
    logic [7:0] vec_q, vec_d;
    logic vvld_q, vvld_d;
    logic int_q, int_d;
    logic nmi_q, nmi_d;
    logic ml_prev_q, ml_prev_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic evt_q, evt_d;

    // Pins are synchronised before any logic looks at them.
    bip_sync #(.W(27)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({mains_low_warning_i, src_i}),
        .q_o(pin_s)
    );

    assign pf_s = pin_s[bip_pkg::SRC_PFAIL];
    assign ml_s = pin_s[26];

    // Jumper matrix: each level takes one of the 26 sources.
    always_comb begin
        for (int i = 0; i < NL; i++) begin
            raw[i] = pick_src(pin_s[25:0], route_q[i]);
        end
    end

    // Lowest-priority level in force for the current mode.
    always_comb begin
        unique case (mode_q)
            bip_pkg::M_ROT: low = rot_q;
            bip_pkg::M_SPEC: low = low_q;
            default: low = bip_pkg::LOW_RST;
        endcase
    end

    assign req = irr_q & ~mask_q;

    bip_prio u_prio (
        .req_i(req),
        .isr_i(isr_q),
        .low_i(low),
        .best_o(best),
        .best_vld_o(best_vld),
        .top_o(top),
        .top_vld_o(top_vld),
        .grant_o(grant)
    );

    // Bus decode: one request is answered once, in the cycle after it appears.
    // A write lands at the edge where the master samples ack, while it still holds it.
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;
    assign rd = bus_req && !wb_we_i;

    // Vectored acknowledge from the processor, or a poll read in polled mode.
    assign take = best_vld && ((inta_i && grant)
                  || (rd && wb_adr_i == bip_pkg::A_POLL && mode_q == bip_pkg::M_POLL));
    assign spur = inta_i && !(best_vld && grant);

    // Configuration registers; all may be rewritten while running.
    always_comb begin
        mode_d = mode_q;
        low_d = low_q;
        base_d = base_q;
        mask_d = mask_q;
        trig_d = trig_q;
        en_d = en_q;
        armed_d = armed_q;
        route_d = route_q;
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_MODE, wb_sel_i, 0)) begin
            mode_d = wb_dat_i[1:0];
            low_d = wb_dat_i[bip_pkg::MODE_LOW_POS +: 3];
            armed_d[0] = 1'b1;
        end
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_BASE, wb_sel_i, 0)) begin
            base_d = wb_dat_i[4:0];
            armed_d[1] = 1'b1;
        end
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_MASK, wb_sel_i, 0)) begin
            mask_d = wb_dat_i[7:0];
            armed_d[2] = 1'b1;
        end
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_TRIG, wb_sel_i, 0)) begin
            trig_d = wb_dat_i[7:0];
        end
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_EVEN, wb_sel_i, 0)) begin
            en_d = wb_dat_i[bip_pkg::EVW-1:0];
        end
        for (int k = 0; k < 4; k++) begin
            if (lane_wr(wr, wb_adr_i, bip_pkg::A_ROUTE0, wb_sel_i, k)) begin
                route_d[k] = wb_dat_i[8*k +: 5];
            end
            if (lane_wr(wr, wb_adr_i, bip_pkg::A_ROUTE1, wb_sel_i, k)) begin
                route_d[k+4] = wb_dat_i[8*k +: 5];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= bip_pkg::MODE_RST;
            low_q <= bip_pkg::LOW_RST;
            base_q <= bip_pkg::BASE_RST;
            mask_q <= bip_pkg::MASK_RST;
            trig_q <= bip_pkg::TRIG_RST;
            en_q <= '0;
            armed_q <= '0;
            for (int k = 0; k < 4; k++) begin
                route_q[k] <= bip_pkg::ROUTE0_RST[8*k +: 5];
                route_q[k+4] <= bip_pkg::ROUTE1_RST[8*k +: 5];
            end
        end else begin
            mode_q <= mode_d;
            low_q <= low_d;
            base_q <= base_d;
            mask_q <= mask_d;
            trig_q <= trig_d;
            en_q <= en_d;
            armed_q <= armed_d;
            route_q <= route_d;
        end
    end

    // Request, in-service and processor-side state.
    always_comb begin
        prev_d = raw;
        irr_d = irr_q;
        isr_d = isr_q;
        rot_d = rot_q;
        vec_d = vec_q;
        vvld_d = 1'b0;
        for (int i = 0; i < NL; i++) begin
            if (trig_q[i]) begin
                // Edge level: a new rising edge wins over a clear in the same cycle.
                irr_d[i] = (irr_q[i] && !(take && best == 3'(i)))
                           || (raw[i] && !prev_q[i]);
            end else begin
                irr_d[i] = raw[i];
            end
        end
        if (take) begin
            isr_d[best] = 1'b1;
        end
        if (inta_i) begin
            // Identifier is base times eight plus level, so the vector is 4 bytes per level.
            vec_d = {base_q, grant ? best : bip_pkg::SPUR_LVL};
            vvld_d = 1'b1;
        end
        if (wr && wb_adr_i == bip_pkg::A_EOI && top_vld) begin
            isr_d[top] = 1'b0;
            if (mode_q == bip_pkg::M_ROT) begin
                rot_d = top;
            end
        end
        int_d = (&armed_q) && mode_q != bip_pkg::M_POLL && grant && !take;
        nmi_d = pf_s && ml_s;
        ml_prev_d = ml_s;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= '0;
            irr_q <= '0;
            isr_q <= '0;
            rot_q <= bip_pkg::LOW_RST;
            vec_q <= '0;
            vvld_q <= 1'b0;
            int_q <= 1'b0;
            nmi_q <= 1'b0;
            ml_prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            irr_q <= irr_d;
            isr_q <= isr_d;
            rot_q <= rot_d;
            vec_q <= vec_d;
            vvld_q <= vvld_d;
            int_q <= int_d;
            nmi_q <= nmi_d;
            ml_prev_q <= ml_prev_d;
        end
    end

    // Sticky events; a set in the same cycle as a clear is kept.
    always_comb begin
        logic [bip_pkg::EVW-1:0] set;
        logic [bip_pkg::EVW-1:0] clr;
        set = '0;
        clr = '0;
        set[bip_pkg::EV_PFAIL] = nmi_d && !nmi_q;
        set[bip_pkg::EV_MLOW] = ml_s && !ml_prev_q;
        set[bip_pkg::EV_SPUR] = spur;
        if (lane_wr(wr, wb_adr_i, bip_pkg::A_EVCLR, wb_sel_i, 0)) begin
            clr = wb_dat_i[bip_pkg::EVW-1:0];
        end
        stat_d = (stat_q & ~clr) | set;
        evt_d = |(stat_d & en_d); // Registered so the pin comes from a flip-flop.
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
            evt_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            evt_q <= evt_d;
        end
    end

    // Read data and acknowledge; unmapped addresses answer with zero.
    always_comb begin
        ack_d = bus_req;
        dat_d = '0;
        if (rd) begin
            unique case (wb_adr_i)
                bip_pkg::A_MODE: dat_d = {25'h0, low_q, 2'h0, mode_q};
                bip_pkg::A_BASE: dat_d = {27'h0, base_q};
                bip_pkg::A_MASK: dat_d = {24'h0, mask_q};
                bip_pkg::A_TRIG: dat_d = {24'h0, trig_q};
                bip_pkg::A_ROUTE0: dat_d = {3'h0, route_q[3], 3'h0, route_q[2],
                                            3'h0, route_q[1], 3'h0, route_q[0]};
                bip_pkg::A_ROUTE1: dat_d = {3'h0, route_q[7], 3'h0, route_q[6],
                                            3'h0, route_q[5], 3'h0, route_q[4]};
                bip_pkg::A_POLL: dat_d = {24'h0, best_vld, 4'h0, best};
                bip_pkg::A_PEND: dat_d = {16'h0, isr_q, irr_q};
                bip_pkg::A_EVSTAT: dat_d = {29'h0, stat_q};
                bip_pkg::A_EVEN: dat_d = {29'h0, en_q};
                default: dat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign int_o = int_q;
    assign vec_o = vec_q;
    assign vec_valid_o = vvld_q;
    assign nmi_o = nmi_q;
    assign evt_irq_o = evt_q;

    // Checks on the prioritizer outputs.
    a_int_needs_arm: assert property (@(posedge clk_i) disable iff (rst_i)
        int_o |-> $past(&armed_q))
        else $error("interrupt raised before configuration");
    a_int_outranks: assert property (@(posedge clk_i) disable iff (rst_i)
        int_o |-> $past(grant) && $past(req[best]))
        else $error("interrupt without an outranking request");
    a_poll_no_int: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(mode_q) == bip_pkg::M_POLL |-> !int_o)
        else $error("interrupt raised in polled mode");
    a_vec_layout: assert property (@(posedge clk_i) disable iff (rst_i)
        inta_i && grant |=> vec_valid_o && vec_o == {$past(base_q), $past(best)})
        else $error("vector identifier wrong");
    a_nest_order: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_q == bip_pkg::M_NEST && req[0] |-> best == 3'h0)
        else $error("level zero not highest");
    a_rot_lowest: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == bip_pkg::A_EOI && top_vld && mode_q == bip_pkg::M_ROT
        |=> rot_q == $past(top) && !isr_q[$past(top)])
        else $error("serviced level did not become lowest");
    a_mask_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        int_o |-> $past((irr_q & ~mask_q) != 8'h00))
        else $error("masked level selected");
    a_nmi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 nmi_o == $past(pf_s && ml_s))
        else $error("power fail line not followed");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule
`default_nettype wire

// ===== bip_cpu_model.sv
// Behavioural model of the host processor that answers the interrupt line.
`timescale 1ns/10ps
`default_nettype none
module bip_cpu_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Controls from the testbench.
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic kick_i,
    // Prioritizer side.
    input wire logic int_i,
    input wire logic [7:0] vec_i,
    input wire logic vec_valid_i,
    output logic inta_o,
    // Last identifier, derived vector address and number of answers.
    output logic [7:0] id_o,
    output logic [9:0] addr_o,
    output int cnt_o
);
    int wait_q;
    logic busy_q;
    // One acknowledge per request; the next waits until the identifier is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inta_o <= 1'b0;
            busy_q <= 1'b0;
            wait_q <= 0;
            id_o <= 8'h00;
            addr_o <= 10'h000;
            cnt_o <= 0;
        end else begin
            inta_o <= 1'b0;
            if (vec_valid_i) begin
                id_o <= vec_i;
                addr_o <= {vec_i, 2'h0};
                cnt_o <= cnt_o + 1;
                busy_q <= 1'b0;
            end else if (!busy_q && (kick_i || (en_i && int_i))) begin
                if (kick_i || wait_q >= (slow_i ? 8 : 0)) begin
                    inta_o <= 1'b1;
                    busy_q <= 1'b1;
                    wait_q <= 0;
                end else begin
                    wait_q <= wait_q + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== board_interrupt_prioritizer_tb_top.sv
// Self-checking testbench of the board interrupt prioritizer.
`timescale 1ns/10ps
`default_nettype none
module board_interrupt_prioritizer_tb_top;
    logic clk_i, rst_i, cyc, stb, we, wb_ack, mlow, inta, int_o, vec_valid, nmi, evt;
    logic en, slow, kick;
    logic [7:0] adr, vec, id;
    logic [3:0] sel;
    logic [31:0] dat, wb_dat, rd;
    logic [25:0] src;
    logic [9:0] addr;
    logic [4:0] base;
    int cnt, seen, fails, checks;
    // Design and processor model.
    bip_core u_bip_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .src_i(src), .mains_low_warning_i(mlow), .inta_i(inta),
        .int_o(int_o), .vec_o(vec), .vec_valid_o(vec_valid), .nmi_o(nmi), .evt_irq_o(evt));
    bip_cpu_model u_bip_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .slow_i(slow),
        .kick_i(kick), .int_i(int_o), .vec_i(vec), .vec_valid_i(vec_valid), .inta_o(inta),
        .id_o(id), .addr_o(addr), .cnt_o(cnt));
    // Clock at 40 MHz.
    always #12.5 clk_i = ~clk_i;
    // Prints the verdict and ends the run.
    task wrap_up();
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Compares a value and reports a mismatch.
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled high.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat;
        chk({31'h0, wb_ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Reads a register and compares it.
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Checks that no interrupt is raised for a number of cycles.
    task quiet(input int n);
        repeat (n) begin
            @(posedge clk_i);
            chk({31'h0, int_o}, 32'h0);
        end
    endtask
    // Raises a set of request sources together.
    task raise(input logic [25:0] m);
        @(posedge clk_i);
        src <= src | m;
    endtask
    // Waits for the model's next answer and checks identifier and vector address.
    task take(input logic [2:0] l);
        int n;
        n = 0;
        while (cnt == seen && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, cnt != seen}, 32'h1);
        seen = cnt;
        chk({24'h0, id}, {24'h0, base, l});
        chk({22'h0, addr}, 32'(base) * 32 + 32'(l) * 4);
    endtask
    // Drops a source, lets it pass the synchroniser, then ends service.
    task finish(input int s);
        @(posedge clk_i);
        src[s] <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b1, bip_pkg::A_EOI, 32'h0);
    endtask
    // Watchdog against a hang.
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, mlow, kick, slow} = 6'h00;
        {adr, dat, src} = '0;
        sel = 4'hf;
        en = 1'b1;
        {seen, fails, checks} = '0;
        base = 5'h08;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(bip_pkg::A_MODE, 32'h70);
        rdchk(bip_pkg::A_BASE, 32'h08);
        rdchk(bip_pkg::A_MASK, 32'hff);
        rdchk(bip_pkg::A_TRIG, 32'hff);
        rdchk(bip_pkg::A_ROUTE0, 32'h0a090807);
        rdchk(bip_pkg::A_ROUTE1, 32'h0e0d0c0b);
        rdchk(bip_pkg::A_EVEN, 32'h0);
        rdchk(8'h30, 32'h0);
        // Output held off until mode, mask and base are written.
        wb(1'b1, bip_pkg::A_TRIG, 32'h0);
        raise(26'h80);
        wb(1'b1, bip_pkg::A_MODE, 32'h70);
        wb(1'b1, bip_pkg::A_MASK, 32'h0);
        quiet(20);
        base = 5'h10;
        wb(1'b1, bip_pkg::A_BASE, 32'h10);
        take(0);
        finish(7);
        // Nested ranking against the level in service.
        raise(26'h1400);
        take(3);
        quiet(20);
        raise(26'h100);
        take(1);
        finish(8);
        finish(10);
        take(5);
        finish(12);
        // Masking by one byte write.
        wb(1'b1, bip_pkg::A_MASK, 32'hf7);
        raise(26'h480);
        take(3);
        finish(10);
        quiet(20);
        wb(1'b1, bip_pkg::A_MASK, 32'h0);
        take(0);
        finish(7);
        // Every source routed in turn to level 0.
        for (int s = 0; s < bip_pkg::NSRC; s++) begin
            wb(1'b1, bip_pkg::A_ROUTE0, {24'h0a0908, 8'(s)});
            raise(26'h1 << s);
            take(0);
            finish(s);
        end
        wb(1'b1, bip_pkg::A_ROUTE0, 32'h0a090807);
        // Edge request latched from a short pulse, answered once.
        wb(1'b1, bip_pkg::A_TRIG, 32'h01);
        raise(26'h80);
        repeat (2) @(posedge clk_i);
        src[7] <= 1'b0;
        take(0);
        finish(7);
        quiet(20);
        wb(1'b1, bip_pkg::A_TRIG, 32'h0);
        // Rotating mode with a slow processor.
        wb(1'b1, bip_pkg::A_MODE, 32'h71);
        slow <= 1'b1;
        raise(26'h80);
        take(0);
        finish(7);
        raise(26'h180);
        take(1);
        finish(8);
        take(0);
        finish(7);
        slow <= 1'b0;
        // Specific mode with level 4 lowest.
        wb(1'b1, bip_pkg::A_MODE, 32'h42);
        raise(26'h2880);
        take(6);
        finish(13);
        take(0);
        finish(7);
        take(4);
        finish(11);
        // Polled mode read through the status register.
        en <= 1'b0;
        wb(1'b1, bip_pkg::A_MODE, 32'h73);
        raise(26'h1200);
        repeat (6) @(posedge clk_i);
        rdchk(bip_pkg::A_POLL, 32'h82);
        finish(9);
        rdchk(bip_pkg::A_POLL, 32'h85);
        finish(12);
        wb(1'b1, bip_pkg::A_MODE, 32'h70);
        // Acknowledge with nothing pending, then the event interrupt.
        @(posedge clk_i);
        kick <= 1'b1;
        @(posedge clk_i);
        kick <= 1'b0;
        take(bip_pkg::SPUR_LVL);
        rdchk(bip_pkg::A_EVSTAT, 32'h4);
        chk({31'h0, evt}, 32'h0);
        wb(1'b1, bip_pkg::A_EVEN, 32'h4);
        repeat (2) @(posedge clk_i);
        chk({31'h0, evt}, 32'h1);
        wb(1'b1, bip_pkg::A_EVCLR, 32'h4);
        repeat (2) @(posedge clk_i);
        chk({31'h0, evt}, 32'h0);
        wb(1'b1, bip_pkg::A_EOI, 32'h0);
        // Non-maskable line needs both the power-fail request and the mains warning.
        raise(26'h1 << bip_pkg::SRC_PFAIL);
        repeat (8) @(posedge clk_i);
        chk({31'h0, nmi}, 32'h0);
        mlow <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({31'h0, nmi}, 32'h1);
        rdchk(bip_pkg::A_EVSTAT, 32'h3);
        wrap_up();
    end
endmodule
`default_nettype wire
